/* File: ccl_blink.sv */
// Field counter that derives the fast and slow cursor blink phases.
`timescale 1ns/1ps
module ccl_blink
  import ccl_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Field tick in, blink phases out.
  ccl_blink_if.source blk
);
  localparam int CNT_W = $clog2(BLINK_SLOW_FIELDS);
  localparam int FAST_BIT = $clog2(BLINK_FAST_FIELDS) - 1;
  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // Fast toggles every 8 fields (1/16 rate), slow every 16 (1/32 rate).
  assign cnt_d = blk.field_tick ? cnt_q + CNT_ONE : cnt_q;
  assign blk.fast_on = ~cnt_q[FAST_BIT];
  assign blk.slow_on = ~cnt_q[CNT_W-1];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

/* File: ccl_blink_if.sv */
// Interface carrying field ticks and blink phases between modules.
`timescale 1ns/1ps
interface ccl_blink_if;
  logic field_tick;
  logic fast_on;
  logic slow_on;
  modport source (input field_tick, output fast_on, output slow_on);
  modport sink (output field_tick, input fast_on, input slow_on);
endinterface

/* File: ccl_crtc_cursor.sv */
// Character row line counter, text cursor and light pen latch.
`timescale 1ns/1ps
module ccl_crtc_cursor
  import ccl_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Host I/O port access.
  input wire logic [11:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  // Controller configuration.
  input wire logic color_addr_sel,
  input wire logic [7:0] write_protect_control,
  input wire logic [1:0] interlace_mode,
  input wire logic scan_double,
  input wire logic mono_adapter_mode,
  input wire logic color_adapter_mode,
  input wire logic enhanced_text_autoswitch,
  input wire logic ext_blink_override,
  input wire logic [4:0] alt_cell_height,
  // Raster timing.
  input wire logic line_tick,
  input wire logic field_tick,
  input wire logic field_odd,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [ADDR_W-1:0] cursor_loc,
  // Light pen pin.
  input wire logic pen_strobe_n,
  // Row, cursor and pen latch outputs.
  output logic [4:0] scan_line,
  output logic row_end,
  output logic cursor_on,
  output logic pen_latch
);
  localparam logic [5:0] STEP_ONE = 6'h01;
  localparam logic [5:0] STEP_TWO = 6'h02;

  // Register storage.
  logic [7:0] index_q;
  logic [4:0] cell_height_reg_q;
  logic [4:0] cursor_top_reg_q;
  logic [1:0] cursor_mode_q;
  logic [4:0] cursor_bottom_reg_q;
  logic [7:0] pen_position_high_q;
  logic [7:0] pen_position_low_q;
  logic pen_latch_q;
  logic pen_latch_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;

  // Row engine state.
  logic [4:0] line_q;
  logic [4:0] line_d;
  ccl_dbl_e dbl_q;
  ccl_dbl_e dbl_d;
  logic row_end_q;
  logic row_end_d;
  logic cursor_on_q;
  logic cursor_on_d;

  // Port decode.
  logic hit_index;
  logic hit_data;
  logic hit_status;
  logic hit_pen_clear;
  logic hit_pen_set;
  logic crtc_wr_ok;
  logic pen_wr_ok;
  logic wr_index;
  logic wr_data;

  assign hit_index = ccl_port_hit(io_addr, color_addr_sel, OFS_INDEX);
  assign hit_data = ccl_port_hit(io_addr, color_addr_sel, OFS_DATA);
  assign hit_status = ccl_port_hit(io_addr, color_addr_sel, OFS_STATUS);
  assign hit_pen_clear =
    ccl_port_hit(io_addr, color_addr_sel, OFS_PEN_CLEAR);
  assign hit_pen_set = color_addr_sel ? (io_addr == IO_PEN_SET_COLOR) :
    ((io_addr == IO_PEN_SET_MONO_A) || (io_addr == IO_PEN_SET_MONO_B));

  assign crtc_wr_ok = ~write_protect_control[WRP_CRTC_BIT];
  assign pen_wr_ok = ~write_protect_control[WRP_PEN_BIT];
  assign wr_index = io_wr && hit_index;
  assign wr_data = io_wr && hit_data && crtc_wr_ok;

  // Light pen events.
  logic pen_level;
  logic pen_level_q;
  logic strobe_fall;
  logic set_evt;
  logic clr_evt;
  logic load_pos;

  ccl_sync3 #(
    .RESET_LEVEL(1'b1)
  ) u_pen_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin(pen_strobe_n),
    .level(pen_level)
  );

  assign strobe_fall = pen_level_q && !pen_level;
  assign set_evt = (io_wr && hit_pen_set && pen_wr_ok) || strobe_fall;
  assign clr_evt = io_wr && hit_pen_clear && pen_wr_ok;
  // A set in the same cycle as a clear wins.
  assign pen_latch_d = set_evt ? 1'b1 : (clr_evt ? 1'b0 : pen_latch_q);
  assign load_pos = set_evt && !pen_latch_q;

  // Mode qualification.
  logic legacy_mode;
  logic cursor_mode_ok;
  logic [4:0] height;

  assign legacy_mode = mono_adapter_mode || color_adapter_mode;
  assign cursor_mode_ok = legacy_mode || enhanced_text_autoswitch;
  assign height = legacy_mode ? cell_height_reg_q : alt_cell_height;

  // Row line stepping.
  logic sync_video;
  logic dup_lines;
  logic [5:0] step;
  logic [4:0] first_line;
  logic [5:0] next_line;
  logic row_done;

  assign sync_video = (interlace_mode == ILACE_SYNC_VIDEO);
  // Doubling in sync-and-video shows both fields' lines each field.
  assign dup_lines = scan_double && !sync_video;
  assign step = (sync_video && !scan_double) ? STEP_TWO : STEP_ONE;
  assign first_line = (sync_video && !scan_double) ?
    {4'h0, field_odd} : RST_LINE;
  assign next_line = {1'b0, line_q} + step;
  // Ending on overflow past the height accepts odd and even heights.
  assign row_done = next_line > {1'b0, height};

  always_comb begin
    line_d = line_q;
    dbl_d = dbl_q;
    row_end_d = 1'b0;
    if (field_tick) begin
      line_d = first_line;
      dbl_d = DBL_FIRST;
    end else if (line_tick) begin
      case (dbl_q)
        DBL_FIRST: begin
          if (dup_lines) begin
            dbl_d = DBL_SECOND;
          end else if (row_done) begin
            line_d = first_line;
            row_end_d = 1'b1;
          end else begin
            line_d = next_line[4:0];
          end
        end
        DBL_SECOND: begin
          dbl_d = DBL_FIRST;
          if (row_done) begin
            line_d = first_line;
            row_end_d = 1'b1;
          end else begin
            line_d = next_line[4:0];
          end
        end
        default: begin
          dbl_d = DBL_FIRST;
        end
      endcase
    end
  end

  // Cursor blink phases.
  ccl_blink_if blk_if ();
  assign blk_if.field_tick = field_tick;

  ccl_blink u_blink (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .blk(blk_if.source)
  );

  // Blink selection.
  logic blink_show;
  logic full_block;
  logic in_span;
  logic at_cursor;

  always_comb begin
    blink_show = 1'b0;
    if (!legacy_mode) begin
      blink_show = blk_if.fast_on;
    end else if (!ext_blink_override) begin
      case (cursor_mode_q)
        CMODE_FAST: blink_show = blk_if.fast_on;
        CMODE_SLOW: blink_show = blk_if.slow_on;
        CMODE_OFF_A: blink_show = 1'b0;
        CMODE_OFF_B: blink_show = 1'b0;
        default: blink_show = 1'b0;
      endcase
    end else begin
      case (cursor_mode_q)
        CMODE_FAST: blink_show = 1'b1;
        CMODE_OFF_B: blink_show = blk_if.fast_on;
        CMODE_SLOW: blink_show = blk_if.slow_on;
        default: blink_show = 1'b0;
      endcase
    end
  end

  // Lines are compared in logical units, so doubling doubles the cursor.
  assign full_block = cursor_bottom_reg_q > height;
  // Start and end compare directly, with no parity constraint.
  assign in_span = full_block || ((line_q >= cursor_top_reg_q) &&
    (line_q <= cursor_bottom_reg_q));
  assign at_cursor = (mem_addr == cursor_loc);
  assign cursor_on_d = cursor_mode_ok && at_cursor && in_span &&
    blink_show;

  // Read data selection.
  always_comb begin
    rdata_d = RST_BYTE;
    if (hit_index) begin
      rdata_d = index_q;
    end else if (hit_status) begin
      rdata_d[STAT_PEN_BIT] = pen_latch_q;
    end else if (hit_data) begin
      case (index_q)
        IDX_CELL_HEIGHT: rdata_d[LINE_MSB:0] = cell_height_reg_q;
        IDX_CURSOR_TOP: rdata_d[LINE_MSB:0] = cursor_top_reg_q;
        IDX_CURSOR_BOTTOM: rdata_d[LINE_MSB:0] = cursor_bottom_reg_q;
        IDX_PEN_HIGH: rdata_d = pen_position_high_q;
        IDX_PEN_LOW: rdata_d = pen_position_low_q;
        default: rdata_d = RST_BYTE;
      endcase
    end
  end

  // Register file.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      index_q <= RST_BYTE;
      cell_height_reg_q <= RST_LINE;
      cursor_top_reg_q <= RST_LINE;
      cursor_mode_q <= RST_CMODE;
      cursor_bottom_reg_q <= RST_LINE;
    end else begin
      if (wr_index) begin
        index_q <= io_wdata;
      end
      if (wr_data && (index_q == IDX_CELL_HEIGHT)) begin
        cell_height_reg_q <= io_wdata[LINE_MSB:0];
      end
      if (wr_data && (index_q == IDX_CURSOR_TOP)) begin
        cursor_top_reg_q <= io_wdata[LINE_MSB:0];
        cursor_mode_q <= io_wdata[CMODE_MSB:CMODE_LSB];
      end
      if (wr_data && (index_q == IDX_CURSOR_BOTTOM)) begin
        cursor_bottom_reg_q <= io_wdata[LINE_MSB:0];
      end
    end
  end

  // Light pen latch and position capture.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pen_latch_q <= 1'b0;
      pen_level_q <= 1'b1;
      pen_position_high_q <= RST_BYTE;
      pen_position_low_q <= RST_BYTE;
    end else begin
      pen_latch_q <= pen_latch_d;
      pen_level_q <= pen_level;
      if (load_pos) begin
        pen_position_high_q <= 8'(mem_addr >> 8);
        pen_position_low_q <= mem_addr[7:0];
      end
    end
  end

  // Row engine, cursor and read port flops.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      line_q <= RST_LINE;
      dbl_q <= DBL_FIRST;
      row_end_q <= 1'b0;
      cursor_on_q <= 1'b0;
      rdata_q <= RST_BYTE;
      rvalid_q <= 1'b0;
    end else begin
      line_q <= line_d;
      dbl_q <= dbl_d;
      row_end_q <= row_end_d;
      cursor_on_q <= cursor_on_d;
      rdata_q <= io_rd ? rdata_d : rdata_q;
      rvalid_q <= io_rd;
    end
  end

  assign io_rdata = rdata_q;
  assign io_rvalid = rvalid_q;
  assign scan_line = line_q;
  assign row_end = row_end_q;
  assign cursor_on = cursor_on_q;
  assign pen_latch = pen_latch_q;

endmodule

/* File: ccl_crtc_cursor_props.sv */
// Port-level assertions for the cursor, cell and pen block.
`timescale 1ns/1ps
module ccl_crtc_cursor_props
  import ccl_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Host port access.
  input wire logic [11:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid,
  // Configuration and raster timing.
  input wire logic color_addr_sel,
  input wire logic [7:0] write_protect_control,
  input wire logic [1:0] interlace_mode,
  input wire logic scan_double,
  input wire logic line_tick,
  input wire logic field_tick,
  input wire logic field_odd,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [ADDR_W-1:0] cursor_loc,
  input wire logic pen_strobe_n,
  // Design outputs.
  input wire logic [4:0] scan_line,
  input wire logic row_end,
  input wire logic cursor_on,
  input wire logic pen_latch
);
  logic [3:0] quiet_q;
  logic [3:0] quiet_d;
  logic [7:0] hi_w;
  logic set_w;
  logic clr_w;
  logic open_w;
  logic odd_w;
  logic [4:0] first_w;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // Counts quiet pen cycles so that a strobe cannot mask a clear.
  assign quiet_d = !pen_strobe_n ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'h8};
  assign hi_w = color_addr_sel ? IO_HI_COLOR : IO_HI_MONO;
  assign set_w = io_wr && (color_addr_sel ? io_addr == IO_PEN_SET_COLOR
    : (io_addr == IO_PEN_SET_MONO_A || io_addr == IO_PEN_SET_MONO_B));
  assign clr_w = io_wr && io_addr == {hi_w, OFS_PEN_CLEAR};
  assign open_w = !write_protect_control[WRP_PEN_BIT];
  assign odd_w = interlace_mode == ILACE_SYNC_VIDEO && !scan_double;
  assign first_w = {4'h0, odd_w && field_odd};

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      quiet_q <= 4'h0;
    end else begin
      quiet_q <= quiet_d;
    end
  end

  sequence s_clear_open;
    clr_w && open_w && quiet_q == 4'h8;
  endsequence
  sequence s_status_read;
    io_rd && io_addr == {hi_w, OFS_STATUS};
  endsequence

  property p_pen_set;
    set_w && open_w |=> pen_latch;
  endproperty
  property p_pen_clear;
    s_clear_open |=> !pen_latch;
  endproperty
  property p_pen_guard;
    io_wr && !open_w && quiet_q == 4'h8 |=> $stable(pen_latch);
  endproperty
  property p_pen_fall;
    $fell(pen_latch) |-> $past(clr_w) && $past(open_w);
  endproperty
  property p_status;
    s_status_read |=> io_rvalid && io_rdata == {6'h00, $past(pen_latch), 1'b0};
  endproperty
  property p_row_end;
    row_end |-> $past(line_tick) && scan_line == $past(first_w);
  endproperty
  property p_field_start;
    field_tick |=> scan_line == $past(first_w);
  endproperty
  property p_cursor_addr;
    mem_addr != cursor_loc |=> !cursor_on;
  endproperty

  a_pen_set: assert property (p_pen_set)
    else $error("pen set write did not set the latch");
  a_pen_clear: assert property (p_pen_clear)
    else $error("pen clear write did not clear the latch");
  a_pen_guard: assert property (p_pen_guard)
    else $error("protected pen write changed the latch");
  a_pen_fall: assert property (p_pen_fall)
    else $error("pen latch cleared without an open clear write");
  a_status: assert property (p_status)
    else $error("status read did not return the pen latch");
  a_row_end: assert property (p_row_end)
    else $error("row end without a line tick or wrong first line");
  a_field_start: assert property (p_field_start)
    else $error("field start gave the wrong first line");
  a_cursor_addr: assert property (p_cursor_addr)
    else $error("cursor shown away from the cursor location");
endmodule

/* File: ccl_host_model.sv */
// Host processor model: port writes, port reads and the pen strobe.
`timescale 1ns/1ps
module ccl_host_model (
  // Clock.
  input wire logic ref_clk,
  // Port access.
  output logic [11:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid,
  // Pen pin.
  output logic pen_strobe_n
);
  initial begin
    io_addr = 12'h000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
    pen_strobe_n = 1'b1;
  end

  // Idle address and data lines are inverted so stale values never match.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge ref_clk) #1;
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d,
                    output logic ok);
    @(posedge ref_clk) #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge ref_clk) #1;
    io_rd = 1'b0;
    io_addr = ~a;
    ok = io_rvalid === 1'b1;
    d = io_rdata;
  endtask

  // Pen strobe is an active low pulse long enough for the pin filter.
  task automatic pen_pulse();
    @(posedge ref_clk) #1;
    pen_strobe_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    pen_strobe_n = 1'b1;
  endtask
endmodule

/* File: ccl_pkg.sv */
// Constants, types and decode helpers for the cursor, cell and pen block.
package ccl_pkg;

  // Host I/O port map; the middle digit follows the address mode.
  localparam logic [7:0] IO_HI_MONO = 8'h3B;
  localparam logic [7:0] IO_HI_COLOR = 8'h3D;
  localparam logic [3:0] OFS_INDEX = 4'h4;
  localparam logic [3:0] OFS_DATA = 4'h5;
  localparam logic [3:0] OFS_STATUS = 4'hA;
  localparam logic [3:0] OFS_PEN_CLEAR = 4'hB;
  localparam logic [11:0] IO_PEN_SET_MONO_A = 12'h3B9;
  localparam logic [11:0] IO_PEN_SET_MONO_B = 12'h3BC;
  localparam logic [11:0] IO_PEN_SET_COLOR = 12'h3DC;

  // Indexed register numbers.
  localparam logic [7:0] IDX_CELL_HEIGHT = 8'h09;
  localparam logic [7:0] IDX_CURSOR_TOP = 8'h0A;
  localparam logic [7:0] IDX_CURSOR_BOTTOM = 8'h0B;
  localparam logic [7:0] IDX_PEN_HIGH = 8'h10;
  localparam logic [7:0] IDX_PEN_LOW = 8'h11;

  // Field positions.
  localparam int LINE_MSB = 4;
  localparam int CMODE_LSB = 5;
  localparam int CMODE_MSB = 6;
  localparam int WRP_CRTC_BIT = 5;
  localparam int WRP_PEN_BIT = 6;
  localparam int STAT_PEN_BIT = 1;

  // Reset values.
  localparam logic [4:0] RST_LINE = 5'h00;
  localparam logic [1:0] RST_CMODE = 2'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Cursor mode field encodings.
  localparam logic [1:0] CMODE_FAST = 2'h0;
  localparam logic [1:0] CMODE_OFF_A = 2'h1;
  localparam logic [1:0] CMODE_OFF_B = 2'h2;
  localparam logic [1:0] CMODE_SLOW = 2'h3;

  // Interlace mode field encodings.
  localparam logic [1:0] ILACE_SYNC = 2'h1;
  localparam logic [1:0] ILACE_SYNC_VIDEO = 2'h3;

  // Blink periods in fields.
  localparam int BLINK_FAST_FIELDS = 16;
  localparam int BLINK_SLOW_FIELDS = 32;

  typedef enum logic {DBL_FIRST, DBL_SECOND} ccl_dbl_e;

  // True when addr is port 3?ofs in the current address mode.
  function automatic logic ccl_port_hit(input logic [11:0] addr,
                                        input logic color,
                                        input logic [3:0] ofs);
    ccl_port_hit = (addr == {(color ? IO_HI_COLOR : IO_HI_MONO), ofs});
  endfunction

endpackage

/* File: ccl_sync3.sv */
// Three-stage pin synchroniser with an agreement filter.
`timescale 1ns/1ps
module ccl_sync3 #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Pin and filtered level.
  input wire logic pin,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic agree;

  // A change counts once the second and third stages agree.
  assign agree = (s2_q == s3_q);
  assign level = level_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= RESET_LEVEL;
      s2_q <= RESET_LEVEL;
      s3_q <= RESET_LEVEL;
      level_q <= RESET_LEVEL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= agree ? s3_q : level_q;
    end
  end
endmodule

/* File: crtc_cursor_cell_lightpen_bench.sv */
// Self-checking bench for the cursor, cell and pen block.
`timescale 1ns/1ps
module crtc_cursor_cell_lightpen_bench
  import ccl_pkg::*;
;
  logic ref_clk, resetn, io_wr, io_rd, io_rvalid, color_addr_sel, scan_double;
  logic mono_adapter_mode, color_adapter_mode, enhanced_text_autoswitch;
  logic ext_blink_override, line_tick, field_tick, field_odd, pen_strobe_n;
  logic row_end, cursor_on, pen_latch;
  logic [11:0] io_addr;
  logic [7:0] io_wdata, io_rdata, write_protect_control, d;
  logic [1:0] interlace_mode, m;
  logic [4:0] alt_cell_height, scan_line, fields;
  logic [15:0] mem_addr, cursor_loc;
  int n_mismatch, checks, k, n, r;

  ccl_crtc_cursor ccl_crtc_cursor_i (.ref_clk, .resetn, .io_addr, .io_wr,
    .io_rd, .io_wdata, .io_rdata, .io_rvalid, .color_addr_sel,
    .write_protect_control, .interlace_mode, .scan_double,
    .mono_adapter_mode, .color_adapter_mode, .enhanced_text_autoswitch,
    .ext_blink_override, .alt_cell_height, .line_tick, .field_tick,
    .field_odd, .mem_addr, .cursor_loc, .pen_strobe_n, .scan_line,
    .row_end, .cursor_on, .pen_latch);
  ccl_host_model ccl_host_model_i (.ref_clk, .io_addr, .io_wr, .io_rd,
    .io_wdata, .io_rdata, .io_rvalid, .pen_strobe_n);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic chkn(input string s, input int e, input int g);
    checks++;
    if (g != e) begin
      n_mismatch++;
      $display("ERROR %s expected %0d seen %0d", s, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    ccl_host_model_i.wr(a, v);
  endtask

  task automatic rdp(input logic [11:0] a, input logic [7:0] e);
    logic ok;
    ccl_host_model_i.rd(a, d, ok);
    if (!ok) begin
      n_mismatch++;
      results();
    end
    chk("read data", e, d);
  endtask

  function automatic logic show_exp(input int c, input logic [4:0] f);
    logic [1:0] mm;
    mm = c[1:0];
    if (c == 8 || (mm == CMODE_FAST && !c[2]) ||
      (mm == CMODE_OFF_B && c[2])) begin
      show_exp = !f[3];
    end else if (mm == CMODE_SLOW) begin
      show_exp = !f[4];
    end else begin
      show_exp = c[2] && mm == CMODE_FAST;
    end
  endfunction

  function automatic logic [11:0] port(input logic [3:0] o);
    port = {color_addr_sel ? IO_HI_COLOR : IO_HI_MONO, o};
  endfunction

  task automatic wreg(input logic [7:0] i, input logic [7:0] v);
    wr(port(OFS_INDEX), i);
    wr(port(OFS_DATA), v);
  endtask

  task automatic rdreg(input logic [7:0] i, input logic [7:0] e);
    wr(port(OFS_INDEX), i);
    rdp(port(OFS_DATA), e);
  endtask

  task automatic latch(input logic e);
    chk("pen latch", {7'h00, e}, {7'h00, pen_latch});
  endtask

  // Starts a field, then ticks lines until the row ends.
  task automatic row(output int len, output int cur);
    @(posedge ref_clk) #1;
    field_tick = 1'b1;
    fields++;
    @(posedge ref_clk) #1;
    field_tick = 1'b0;
    chk("first line", {7'h00, interlace_mode == ILACE_SYNC_VIDEO &&
      !scan_double && field_odd}, {3'h0, scan_line});
    len = 0;
    cur = 0;
    do begin
      @(posedge ref_clk) #1;
      cur += int'(cursor_on === 1'b1);
      line_tick = 1'b1;
      @(posedge ref_clk) #1;
      line_tick = 1'b0;
      len++;
    end while (row_end !== 1'b1 && len < 40);
  endtask

  task automatic rc(input logic [1:0] il, input logic dbl, input logic odd,
    input logic [7:0] h, input logic [7:0] s, input logic [7:0] e,
    input int elen, input int ecur);
    int len, cur;
    interlace_mode = il;
    scan_double = dbl;
    field_odd = odd;
    wreg(IDX_CELL_HEIGHT, h);
    wreg(IDX_CURSOR_TOP, s);
    wreg(IDX_CURSOR_BOTTOM, e);
    row(len, cur);
    chkn("row lines", elen, len);
    chkn("cursor lines", ecur, cur);
  endtask

  initial begin
    {resetn, scan_double, color_adapter_mode} = '0;
    {enhanced_text_autoswitch, line_tick, field_tick, field_odd} = '0;
    {write_protect_control, interlace_mode, mem_addr, cursor_loc} = '0;
    {color_addr_sel, mono_adapter_mode, ext_blink_override} = 3'h7;
    alt_cell_height = 5'h03;
    fields = 5'h00;
    repeat (20) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    wreg(IDX_CURSOR_TOP, 8'h6E);
    rdreg(IDX_CURSOR_TOP, 8'h0E);
    wreg(IDX_CURSOR_BOTTOM, 8'h1F);
    rdreg(IDX_CURSOR_BOTTOM, 8'h1F);
    rdreg(8'h3F, 8'h00);
    $display("test registers done");
    rc(2'h0, 1'b0, 1'b0, 8'h03, 8'h01, 8'h02, 4, 2);
    rc(2'h1, 1'b0, 1'b0, 8'h03, 8'h01, 8'h02, 4, 2);
    rc(2'h2, 1'b0, 1'b0, 8'h03, 8'h01, 8'h02, 4, 2);
    rc(2'h0, 1'b1, 1'b0, 8'h03, 8'h01, 8'h02, 8, 4);
    rc(2'h3, 1'b0, 1'b0, 8'h03, 8'h01, 8'h02, 2, 1);
    rc(2'h3, 1'b0, 1'b1, 8'h03, 8'h01, 8'h02, 2, 1);
    rc(2'h3, 1'b1, 1'b0, 8'h03, 8'h01, 8'h02, 4, 2);
    rc(2'h3, 1'b0, 1'b1, 8'h02, 8'h01, 8'h01, 1, 1);
    rc(2'h0, 1'b0, 1'b0, 8'h03, 8'h02, 8'h05, 4, 4);
    rc(2'h3, 1'b0, 1'b0, 8'h03, 8'h02, 8'h04, 2, 2);
    cursor_loc = 16'h0001;
    rc(2'h0, 1'b0, 1'b0, 8'h03, 8'h00, 8'h03, 4, 0);
    cursor_loc = 16'h0000;
    $display("test rows done");
    for (k = 0; k < 9; k++) begin
      ext_blink_override = k[2];
      mono_adapter_mode = k < 8 && !k[0];
      color_adapter_mode = k < 8 && k[0];
      enhanced_text_autoswitch = k == 8;
      m = k == 8 ? CMODE_OFF_A : k[1:0];
      wreg(IDX_CURSOR_TOP, {1'b0, m, 5'h00});
      repeat (32) begin
        row(r, n);
        chkn("blink lines", show_exp(k, fields) ? 4 : 0,
          n);
      end
    end
    alt_cell_height = 5'h01;
    rc(2'h0, 1'b0, 1'b0, 8'h03, 8'h00, 8'h00, 2, 0);
    $display("test blink done");
    mem_addr = 16'h1234;
    wr(IO_PEN_SET_COLOR, 8'h00);
    latch(1'b1);
    mem_addr = 16'h5678;
    wr(IO_PEN_SET_COLOR, 8'hFF);
    rdreg(IDX_PEN_HIGH, 8'h12);
    rdreg(IDX_PEN_LOW, 8'h34);
    rdp(port(OFS_STATUS), 8'h02);
    wr({IO_HI_MONO, OFS_PEN_CLEAR}, 8'h00);
    latch(1'b1);
    wr(port(OFS_PEN_CLEAR), 8'h5A);
    latch(1'b0);
    rdp(port(OFS_STATUS), 8'h00);
    color_addr_sel = 1'b0;
    wr(IO_PEN_SET_COLOR, 8'h00);
    latch(1'b0);
    for (k = 0; k < 2; k++) begin
      wr(k == 0 ? IO_PEN_SET_MONO_A : IO_PEN_SET_MONO_B, 8'h00);
      latch(1'b1);
      wr(port(OFS_PEN_CLEAR), 8'h00);
      latch(1'b0);
    end
    write_protect_control = 8'h40;
    wr(IO_PEN_SET_MONO_B, 8'h00);
    latch(1'b0);
    write_protect_control = 8'h00;
    wr(IO_PEN_SET_MONO_B, 8'h00);
    write_protect_control = 8'h40;
    wr(port(OFS_PEN_CLEAR), 8'h00);
    latch(1'b1);
    write_protect_control = 8'h00;
    wr(port(OFS_PEN_CLEAR), 8'h00);
    mem_addr = 16'hABCD;
    ccl_host_model_i.pen_pulse();
    for (k = 0; k < 10 && pen_latch !== 1'b1; k++) @(posedge ref_clk);
    latch(1'b1);
    rdreg(IDX_PEN_HIGH, 8'hAB);
    rdreg(IDX_PEN_LOW, 8'hCD);
    $display("test pen done");
    results();
  end
endmodule

bind ccl_crtc_cursor ccl_crtc_cursor_props #(.ADDR_W(ADDR_W))
  ccl_crtc_cursor_props_i (.ref_clk, .resetn, .io_addr, .io_wr, .io_rd,
  .io_rdata, .io_rvalid, .color_addr_sel, .write_protect_control,
  .interlace_mode, .scan_double, .line_tick, .field_tick, .field_odd,
  .mem_addr, .cursor_loc, .pen_strobe_n, .scan_line, .row_end,
  .cursor_on, .pen_latch);
